// file: include/dps_pkg.sv
// Constants shared by the drive parameter store
package dps_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ      = 200;
    localparam int TICK_US      = 10;
    localparam int TICK_CYC     = TICK_US * CLK_MHZ;
    localparam int TENTH_S_US   = 100000;
    localparam int TICKS_PER_UNIT = TENTH_S_US / TICK_US;
    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IX_RAMP1  = 8'h07;
    localparam logic [7:0] IX_RAMP2  = 8'h11;
    localparam logic [7:0] IX_HSMAX  = 8'h12;
    localparam logic [7:0] IX_FSCALE = 8'h14;
    localparam logic [7:0] IX_STALL  = 8'h15;
    localparam logic [7:0] IX_BRAKE  = 8'h1e;
    localparam logic [7:0] IX_WLOCK  = 8'h4d;
    localparam logic [7:0] IX_REVINH = 8'h4e;
    localparam logic [7:0] IX_OPMODE = 8'h4f;
    localparam logic [7:0] IX_BIAS   = 8'h62;
    localparam logic [7:0] IX_GAIN   = 8'h63;
    localparam logic [7:0] IX_CTRL   = 8'h70;
    localparam logic [7:0] IX_KFREQ  = 8'h71;
    localparam logic [7:0] IX_STAT   = 8'h72;
    // ------------------------------------------------------------
    // Reset values and ranges (0.01 Hz, 0.1 s, percent units)
    // ------------------------------------------------------------
    localparam logic [15:0] RST_RAMP1  = 16'h0032;
    localparam logic [15:0] RST_RAMP2  = 16'h0000;
    localparam logic [15:0] RST_HSMAX  = 16'h2ee0;
    localparam logic [15:0] RST_FSCALE = 16'h1770;
    localparam logic [7:0]  RST_STALL  = 8'h96;
    localparam logic [7:0]  RST_BRAKE  = 8'h03;
    localparam logic [15:0] RST_BIAS   = 16'h0000;
    localparam logic [15:0] RAMP_MIN   = 16'h0001;
    localparam logic [15:0] RAMP_MAX   = 16'h8ca0;
    localparam logic [15:0] HSMAX_MIN  = 16'h2ee0;
    localparam logic [15:0] FREQ_MAX   = 16'h8ca0;
    localparam logic [15:0] FS_MIN     = 16'h0064;
    localparam logic [15:0] STALL_MIN  = 16'h0078;
    localparam logic [15:0] STALL_MAX  = 16'h00b4;
    localparam logic [15:0] BRAKE_MAX  = 16'h001e;
    localparam logic [15:0] BIAS_MAX   = 16'h2ee0;
    localparam logic [15:0] FMAX_STD   = 16'h2ee0;
    localparam logic [15:0] FINE_LIM   = 16'h2710;
    localparam logic [15:0] COARSE_STEP = 16'h000a;
    localparam logic [15:0] BOOL_MAX   = 16'h0001;
    localparam logic [15:0] OPM_MAX    = 16'h0002;
    // ------------------------------------------------------------
    // Modes, fields, bus codes
    // ------------------------------------------------------------
    localparam logic [1:0] OPM_SWITCH = 2'h0;
    localparam logic [1:0] OPM_KEYPAD = 2'h1;
    localparam logic [1:0] OPM_EXT    = 2'h2;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_REV = 1;
    localparam int CTRL_EXT = 2;
    localparam int ST_EXT      = 0;
    localparam int ST_OUT_EN   = 1;
    localparam int ST_WR_REJ   = 2;
    localparam int ST_REV_REJ  = 3;
    localparam int ST_MODE_REJ = 4;
    localparam int ST_HS_SET   = 5;
    localparam int ST_DIR_REV  = 6;
    localparam int REF_SHIFT   = 10;
    localparam logic [10:0] REF_FS = 11'h400;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;
endpackage

// file: design/dps_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dps_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,   // System clock
    input  wire logic         i_reset, // Synchronous reset
    input  wire logic [W-1:0] i_async, // Pin level
    output logic      [W-1:0] o_level  // Filtered level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dps_sync_s;

    dps_sync_s s_r;
    dps_sync_s s_nxt;

    always_comb begin
        s_nxt    = s_r;
        s_nxt.s1 = i_async;
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        // A change counts only once stages two and three agree
        for (int i = 0; i < W; i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.q[i] = s_r.s3[i];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_level = s_r.q;
endmodule

// file: design/dps_ramp.sv
// Ramp generator: steps output frequency toward target
`timescale 1ns/1ps
module dps_ramp (
    input  wire logic        i_clk,    // System clock
    input  wire logic        i_reset,  // Synchronous reset
    input  wire logic        i_tick,   // 10 us enable pulse
    input  wire logic        i_clr,    // Force output to zero
    input  wire logic [15:0] i_target, // Target, 0.01 Hz
    input  wire logic [15:0] i_fref,   // Ramp reference frequency
    input  wire logic [15:0] i_ramp_t, // Ramp time, 0.1 s
    output logic      [15:0] o_freq    // Output frequency
);
    typedef struct packed {
        logic [31:0] acc;
        logic [15:0] freq;
    } dps_ramp_s;

    dps_ramp_s   s_r;
    dps_ramp_s   s_nxt;
    logic [31:0] thr;

    // time scales
    // Threshold is the ramp time in ticks; each tick adds the reference,
    // so zero to reference takes exactly the ramp time
    assign thr = 32'(i_ramp_t) * 32'(dps_pkg::TICKS_PER_UNIT);

    always_comb begin
        s_nxt = s_r;
        if (i_clr) begin
            s_nxt.acc  = '0;
            s_nxt.freq = '0;
        end else if (s_r.freq == i_target) begin
            s_nxt.acc = '0;
        end else if (thr != '0 && s_r.acc >= thr) begin
            s_nxt.acc = s_r.acc - thr;
            if (s_r.freq < i_target) begin
                s_nxt.freq = s_r.freq + 16'h0001;
            end else begin
                s_nxt.freq = s_r.freq - 16'h0001;
            end
        end else if (i_tick) begin
            s_nxt.acc = s_r.acc + 32'(i_fref);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_freq = s_r.freq;
endmodule

// file: design/dps_top.sv
// Drive parameter store: AHB-Lite registers, write policy, mode and run control
//
// Contract
// - Write lock 0/1, reset 0, blocks parameter writes
// - Operation mode stays writable in external mode
// - Reverse inhibit 0/1, refuses reverse run
// - Operation mode 0/1/2, zero allows switching
// - Mode 2 locks external, rejects keypad request
// - Ramp2 0.1-3600 s; zero makes shutoff disable
// - Ramp2 nonzero: shutoff selects second ramp
// - High-speed ceiling replaces max limit once set
// - Full-scale frequency sets 5 V output
// - Full-scale and gain: latest write wins
// - Gain write updates stored maximum frequency
// - Ramp time spans zero to maximum frequency
// - Stall 120-180 step 10, zero disables
// - Coarse resolution above 100 Hz, 1000 s
// - Bias 0-120 Hz gives 0 V output
// - Gain 1-360 Hz gives 5 V output
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dps_top (
    input  wire logic        i_clk,        // System clock, 200 MHz
    input  wire logic        i_reset,      // Synchronous reset, active high
    input  wire logic        i_hsel,       // AHB slave select
    input  wire logic [31:0] i_haddr,      // AHB address
    input  wire logic [1:0]  i_htrans,     // AHB transfer type
    input  wire logic        i_hwrite,     // AHB write
    input  wire logic [2:0]  i_hsize,      // AHB size
    input  wire logic [31:0] i_hwdata,     // AHB write data
    input  wire logic        i_hready,     // AHB bus ready
    output logic      [31:0] o_hrdata,     // AHB read data
    output logic             o_hreadyout,  // AHB slave ready
    output logic             o_hresp,      // AHB response, always OKAY
    input  wire logic        i_term_fwd,   // Forward run terminal
    input  wire logic        i_term_rev,   // Reverse run terminal
    input  wire logic        i_shutoff_terminal_input, // Shutoff terminal
    input  wire logic [10:0] i_ref_level,  // Reference, 1024 = 5 V
    output logic      [15:0] o_freq,       // Output frequency, 0.01 Hz
    output logic             o_dir_rev,    // Output direction reverse
    output logic             o_out_en,     // Output enable
    output logic             o_ext_mode,   // External-terminal operation
    output logic             o_stall_en,   // Stall prevention enabled
    output logic      [7:0]  o_stall_pct,  // Stall level, percent
    output logic      [7:0]  o_brake_duty  // Brake duty, percent
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] hrdata;
        logic        hready;
        logic        wr_pend;
        logic [7:0]  wr_ix;
        logic [15:0] ramp1;
        logic [15:0] ramp2;
        logic [15:0] hsmax;
        logic [15:0] fscale;
        logic [15:0] bias;
        logic [15:0] kfreq;
        logic [7:0]  stall;
        logic [7:0]  brake;
        logic        stall_en;
        logic        wlock;
        logic        revinh;
        logic [1:0]  opmode;
        logic        hs_set;
        logic [2:0]  ctrl;
        logic        ext;
        logic        wr_rej;
        logic        rev_rej;
        logic        mode_rej;
        logic [15:0] tick_cnt;
        logic        tick;
        logic        out_en;
        logic        dir_rev;
        logic        clr;
        logic [15:0] target;
        logic [15:0] ramp_t;
    } dps_top_s;

    dps_top_s    s_r;
    dps_top_s    s_nxt;
    logic [2:0]  term;
    logic [15:0] freq;

    // ------------------------------------------------------------
    // Terminal synchronisers and ramp
    // ------------------------------------------------------------
    dps_sync #(
        .W (3)
    ) u_sync (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_async ({i_shutoff_terminal_input, i_term_rev, i_term_fwd}),
        .o_level (term)
    );

    dps_ramp u_ramp (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_tick   (s_r.tick),
        .i_clr    (s_r.clr),
        .i_target (s_r.target),
        .i_fref   (s_r.fscale),
        .i_ramp_t (s_r.ramp_t),
        .o_freq   (freq)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // resolution check
    // Values above the fine limit must sit on the coarse step
    function automatic logic in_rng(input logic [31:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi, input logic coarse);
        logic fine_ok;
        fine_ok = !(coarse || v[15:0] > dps_pkg::FINE_LIM)
                  || (v[15:0] % dps_pkg::COARSE_STEP) == 16'h0000;
        return v[31:16] == 16'h0000 && v[15:0] >= lo && v[15:0] <= hi && fine_ok;
    endfunction

    function automatic logic [31:0] rd(input dps_top_s v, input logic [7:0] ix);
        logic [31:0] d;
        d = '0;
        unique case (ix)
            dps_pkg::IX_RAMP1:  d[15:0] = v.ramp1;
            dps_pkg::IX_RAMP2:  d[15:0] = v.ramp2;
            dps_pkg::IX_HSMAX:  d[15:0] = v.hsmax;
            dps_pkg::IX_FSCALE,
            dps_pkg::IX_GAIN:   d[15:0] = v.fscale;
            dps_pkg::IX_BIAS:   d[15:0] = v.bias;
            dps_pkg::IX_STALL:  d[7:0]  = v.stall;
            dps_pkg::IX_BRAKE:  d[7:0]  = v.brake;
            dps_pkg::IX_WLOCK:  d[0]    = v.wlock;
            dps_pkg::IX_REVINH: d[0]    = v.revinh;
            dps_pkg::IX_OPMODE: d[1:0]  = v.opmode;
            dps_pkg::IX_CTRL:   d[2:0]  = v.ctrl;
            dps_pkg::IX_KFREQ:  d[15:0] = v.kfreq;
            dps_pkg::IX_STAT: begin
                d[dps_pkg::ST_EXT]      = v.ext;
                d[dps_pkg::ST_OUT_EN]   = v.out_en;
                d[dps_pkg::ST_WR_REJ]   = v.wr_rej;
                d[dps_pkg::ST_REV_REJ]  = v.rev_rej;
                d[dps_pkg::ST_MODE_REJ] = v.mode_rej;
                d[dps_pkg::ST_HS_SET]   = v.hs_set;
                d[dps_pkg::ST_DIR_REV]  = v.dir_rev;
            end
            default:            d = '0;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [31:0]        wd;
    logic               ok;
    logic               allow;
    logic [15:0]        fmax;
    logic               run;
    logic               want_rev;
    logic signed [17:0] span;
    logic signed [29:0] prod;
    logic signed [29:0] ftgt;
    logic [10:0]        lvl;
    logic [15:0]        tgt;

    always_comb begin
        s_nxt    = s_r;
        wd       = i_hwdata;
        ok       = 1'b0;
        allow    = 1'b0;
        run      = 1'b0;
        want_rev = 1'b0;
        tgt      = '0;
        s_nxt.hready = 1'b1;
        s_nxt.tick   = 1'b0;

        // Register writes land in the data phase
        if (s_r.wr_pend) begin
            s_nxt.wr_pend = 1'b0;
            // write lock
            // Lock blocks every parameter but itself, keypad frequency and control;
            // external mode blocks all but the mode selector, keypad frequency and control
            allow = !s_r.ext && !s_r.wlock;
            unique case (s_r.wr_ix)
                dps_pkg::IX_RAMP1,
                dps_pkg::IX_RAMP2: ok = in_rng(wd, dps_pkg::RAMP_MIN,
                                               dps_pkg::RAMP_MAX, 1'b0)
                                        || (s_r.wr_ix == dps_pkg::IX_RAMP2
                                            && wd == 32'h0000_0000);
                dps_pkg::IX_HSMAX:  ok = in_rng(wd, dps_pkg::HSMAX_MIN,
                                                dps_pkg::FREQ_MAX, 1'b1);
                dps_pkg::IX_FSCALE,
                dps_pkg::IX_GAIN:   ok = in_rng(wd, dps_pkg::FS_MIN,
                                                dps_pkg::FREQ_MAX, 1'b0);
                dps_pkg::IX_BIAS:   ok = in_rng(wd, 16'h0000,
                                                dps_pkg::BIAS_MAX, 1'b0);
                dps_pkg::IX_STALL:  ok = in_rng(wd, dps_pkg::STALL_MIN,
                                                dps_pkg::STALL_MAX, 1'b1)
                                         || wd == 32'h0000_0000;
                dps_pkg::IX_BRAKE:  ok = in_rng(wd, 16'h0000,
                                                dps_pkg::BRAKE_MAX, 1'b0);
                dps_pkg::IX_WLOCK: begin
                    ok    = in_rng(wd, 16'h0000, dps_pkg::BOOL_MAX, 1'b0);
                    allow = !s_r.ext;
                end
                dps_pkg::IX_REVINH: ok = in_rng(wd, 16'h0000,
                                                dps_pkg::BOOL_MAX, 1'b0);
                dps_pkg::IX_OPMODE: begin
                    ok    = in_rng(wd, 16'h0000, dps_pkg::OPM_MAX, 1'b0);
                    allow = !s_r.wlock;
                end
                dps_pkg::IX_KFREQ: begin
                    ok    = in_rng(wd, 16'h0000, dps_pkg::FREQ_MAX, 1'b0);
                    allow = 1'b1;
                end
                dps_pkg::IX_CTRL: begin
                    ok    = 1'b1;
                    allow = 1'b1;
                end
                dps_pkg::IX_STAT: begin
                    // Write one to clear; a new event below still wins
                    if (wd[dps_pkg::ST_WR_REJ]) s_nxt.wr_rej = 1'b0;
                    if (wd[dps_pkg::ST_REV_REJ]) s_nxt.rev_rej = 1'b0;
                    if (wd[dps_pkg::ST_MODE_REJ]) s_nxt.mode_rej = 1'b0;
                end
                default: ;
            endcase
            if (ok && allow) begin
                unique case (s_r.wr_ix)
                    dps_pkg::IX_RAMP1:  s_nxt.ramp1  = wd[15:0];
                    dps_pkg::IX_RAMP2:  s_nxt.ramp2  = wd[15:0];
                    dps_pkg::IX_HSMAX: begin
                        s_nxt.hsmax  = wd[15:0];
                        s_nxt.hs_set = 1'b1;
                    end
                    // gain updates max
                    // One store serves both, so the latest write always wins
                    dps_pkg::IX_FSCALE,
                    dps_pkg::IX_GAIN:   s_nxt.fscale = wd[15:0];
                    dps_pkg::IX_BIAS:   s_nxt.bias   = wd[15:0];
                    dps_pkg::IX_STALL:  s_nxt.stall  = wd[7:0];
                    dps_pkg::IX_BRAKE:  s_nxt.brake  = wd[7:0];
                    dps_pkg::IX_WLOCK:  s_nxt.wlock  = wd[0];
                    dps_pkg::IX_REVINH: s_nxt.revinh = wd[0];
                    dps_pkg::IX_OPMODE: s_nxt.opmode = wd[1:0];
                    dps_pkg::IX_KFREQ:  s_nxt.kfreq  = wd[15:0];
                    dps_pkg::IX_CTRL: begin
                        s_nxt.ctrl = wd[2:0];
                        if ((s_r.opmode == dps_pkg::OPM_EXT && !wd[dps_pkg::CTRL_EXT])
                            || (s_r.opmode == dps_pkg::OPM_KEYPAD
                                && wd[dps_pkg::CTRL_EXT])) begin
                            s_nxt.mode_rej = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (s_r.wr_ix != dps_pkg::IX_STAT) begin
                s_nxt.wr_rej = 1'b1;
            end
        end

        s_nxt.stall_en = (s_nxt.stall != 8'h00);

        // Address phase; read data is taken from the updated copy so a
        // read right after a write sees the new value
        s_nxt.hrdata = '0;
        if (i_hsel && i_hready && i_htrans[1]) begin
            if (i_haddr[31:10] != 22'h000000) begin
                s_nxt.hrdata = '0;
            end else if (i_hwrite) begin
                s_nxt.wr_pend = (i_hsize == dps_pkg::HSIZE_WORD);
                s_nxt.wr_ix   = i_haddr[9:2];
            end else begin
                s_nxt.hrdata = rd(s_nxt, i_haddr[9:2]);
            end
        end

        // 10 us enable for the ramp accumulator
        if (s_r.tick_cnt == 16'(dps_pkg::TICK_CYC - 1)) begin
            s_nxt.tick_cnt = '0;
            s_nxt.tick     = 1'b1;
        end else begin
            s_nxt.tick_cnt = s_r.tick_cnt + 16'h0001;
        end

        unique case (s_r.opmode)
            dps_pkg::OPM_KEYPAD: s_nxt.ext = 1'b0;
            dps_pkg::OPM_EXT:    s_nxt.ext = 1'b1;
            default:             s_nxt.ext = s_r.ctrl[dps_pkg::CTRL_EXT];
        endcase

        fmax = s_r.hs_set ? s_r.hsmax : dps_pkg::FMAX_STD;

        lvl  = (i_ref_level > dps_pkg::REF_FS) ? dps_pkg::REF_FS : i_ref_level;
        span = $signed({2'b00, s_r.fscale}) - $signed({2'b00, s_r.bias});
        prod = 30'(span * $signed({1'b0, lvl}));
        ftgt = 30'($signed({14'h0000, s_r.bias})) + (prod >>> dps_pkg::REF_SHIFT);

        if (s_r.ext) begin
            run      = term[0] ^ term[1];
            want_rev = term[1];
            if (ftgt < 0) begin
                tgt = '0;
            end else if (ftgt > 30'($signed({14'h0000, fmax}))) begin
                tgt = fmax;
            end else begin
                tgt = ftgt[15:0];
            end
        end else begin
            run      = s_r.ctrl[dps_pkg::CTRL_RUN];
            want_rev = s_r.ctrl[dps_pkg::CTRL_REV];
            tgt      = (s_r.kfreq > fmax) ? fmax : s_r.kfreq;
        end

        if (run && want_rev && s_r.revinh) begin
            run             = 1'b0;
            s_nxt.rev_rej   = 1'b1;
        end

        // Direction flips only at standstill, so the ramp runs down first
        if (freq == 16'h0000) begin
            s_nxt.dir_rev = run && want_rev;
        end
        if (!run || (want_rev != s_r.dir_rev)) begin
            tgt = '0;
        end

        s_nxt.out_en = !(term[2] && s_r.ramp2 == 16'h0000);
        s_nxt.clr    = !s_nxt.out_en;
        s_nxt.ramp_t = (term[2] && s_r.ramp2 != 16'h0000) ? s_r.ramp2 : s_r.ramp1;
        s_nxt.target = s_nxt.out_en ? tgt : 16'h0000;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s_r        <= '0;
            s_r.hready <= 1'b1;
            s_r.ramp1  <= dps_pkg::RST_RAMP1;
            s_r.ramp2  <= dps_pkg::RST_RAMP2;
            s_r.hsmax  <= dps_pkg::RST_HSMAX;
            s_r.fscale <= dps_pkg::RST_FSCALE;
            s_r.bias   <= dps_pkg::RST_BIAS;
            s_r.stall  <= dps_pkg::RST_STALL;
            s_r.stall_en <= 1'b1;
            s_r.brake  <= dps_pkg::RST_BRAKE;
            s_r.opmode <= dps_pkg::OPM_SWITCH;
            s_r.out_en <= 1'b1;
            s_r.ramp_t <= dps_pkg::RST_RAMP1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_hrdata     = s_r.hrdata;
    assign o_hreadyout  = s_r.hready;
    assign o_hresp      = 1'b0;
    assign o_freq       = freq;
    assign o_dir_rev    = s_r.dir_rev;
    assign o_out_en     = s_r.out_en;
    assign o_ext_mode   = s_r.ext;
    assign o_stall_en   = s_r.stall_en;
    assign o_stall_pct  = s_r.stall;
    assign o_brake_duty = s_r.brake;
endmodule

// file: testbench/dps_checker.sv
// Port-level assertions for the drive parameter store
`timescale 1ns/1ps
module dps_checker (
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_hsel,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [15:0] o_freq,
    input wire logic        o_dir_rev,
    input wire logic        o_stall_en,
    input wire logic [7:0]  o_stall_pct,
    input wire logic [7:0]  o_brake_duty
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_no_wait: assert property (o_hreadyout && !o_hresp)
        else $error("bus stalled or errored");
    a_idle_rdata: assert property (!$past(i_hsel && i_hready && i_htrans[1]) |-> o_hrdata == 0)
        else $error("read data outside data phase");
    a_stall_flag: assert property (o_stall_en == (o_stall_pct != 8'h00))
        else $error("stall enable disagrees with level");
    a_stall_range: assert property (o_stall_pct inside {8'h00, 8'h78, 8'h82, 8'h8c, 8'h96,
        8'ha0, 8'haa, 8'hb4})
        else $error("stall level off its steps");
    a_brake_range: assert property (o_brake_duty <= 8'h1e)
        else $error("brake duty above range");
    a_reset_vals: assert property ($fell(i_reset) |-> o_stall_pct == 8'h96 && o_freq == 0)
        else $error("bad value after reset");
    a_freq_step: assert property (o_freq == 0
        || 16'(o_freq - $past(o_freq)) inside {0, 1, 16'hffff})
        else $error("frequency jumped");
    a_dir_at_rest: assert property ($changed(o_dir_rev) |->
        $past(o_freq) == 0 || o_freq == 0)
        else $error("direction changed while turning");
    cover property (o_freq != 0 && o_dir_rev);
    cover property (!o_stall_en);
    cover property (i_hsel && i_htrans[1]);
endmodule

// file: testbench/dps_partner.sv
// Terminal-side model: run and shutoff contacts
`timescale 1ns/1ps
module dps_partner (
    input  wire logic       i_clk,  // System clock
    input  wire logic [2:0] i_cmd,  // Shutoff, reverse, forward
    output logic            o_fwd,  // Forward contact
    output logic            o_rev,  // Reverse contact
    output logic            o_shut  // Shutoff contact
);
    // Dry contacts hold a level; moved only after an edge
    always_ff @(posedge i_clk) begin
        {o_shut, o_rev, o_fwd} <= i_cmd;
    end
endmodule

// file: testbench/dps_top_tb.sv
// Self-checking bench for the drive parameter store
`timescale 1ns/1ps
module dps_top_tb;
    logic        i_clk = 1'b0, i_reset = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0;
    logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata;
    logic [1:0]  i_htrans = 2'h0;
    logic [2:0]  cmd = 3'h0;
    logic        fwd, rev, shut, o_hreadyout, o_hresp, o_dir_rev, o_out_en, o_ext_mode, o_stall_en;
    logic [15:0] o_freq;
    logic [7:0]  o_stall_pct, o_brake_duty;
    int          failures = 0, n_checks = 0;
    always #2.5 i_clk = ~i_clk;
    dps_partner dps_partner_i (.i_clk, .i_cmd(cmd), .o_fwd(fwd), .o_rev(rev), .o_shut(shut));
    dps_top dps_top_i (.i_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
        .i_hsize(dps_pkg::HSIZE_WORD), .i_hwdata, .i_hready(o_hreadyout), .o_hrdata,
        .o_hreadyout, .o_hresp, .i_term_fwd(fwd), .i_term_rev(rev),
        .i_shutoff_terminal_input(shut), .i_ref_level(11'h200), .o_freq, .o_dir_rev,
        .o_out_en, .o_ext_mode, .o_stall_en, .o_stall_pct, .o_brake_duty);
    task automatic conclude();
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Edge at which the slave shows ready; a stuck bus ends the run
    task automatic ready_edge();
        for (int n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (o_hreadyout === 1'b1) return;
        end
        failures++;
        conclude();
    endtask
    // One word transfer; a read is compared against v
    task automatic acc(input logic wr, input logic [7:0] ix, input logic [31:0] v);
        i_hsel <= 1'b1;
        i_haddr <= {22'h0, ix, 2'h0};
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        ready_edge();
        i_htrans <= 2'h0;
        i_hwdata <= v;
        ready_edge();
        if (!wr) chk(o_hrdata, v);
    endtask
    task automatic t_reset();
        acc(0, dps_pkg::IX_STALL, 32'h96);
        acc(0, dps_pkg::IX_RAMP2, 32'h0);
        acc(0, dps_pkg::IX_FSCALE, 32'h1770);
        acc(0, dps_pkg::IX_OPMODE, 32'h0);
        acc(0, 8'hff, 32'h0);
        chk(32'(o_brake_duty), 32'h3);
    endtask
    task automatic t_ranges();
        acc(1, dps_pkg::IX_STALL, 32'h7d);
        acc(0, dps_pkg::IX_STALL, 32'h96);
        acc(1, dps_pkg::IX_STALL, 32'h0);
        acc(0, dps_pkg::IX_STALL, 32'h0);
        chk(32'(o_stall_en), 32'h0);
        acc(1, dps_pkg::IX_FSCALE, 32'h2711);
        acc(1, dps_pkg::IX_GAIN, 32'h4e20);
        acc(0, dps_pkg::IX_FSCALE, 32'h4e20);
        acc(1, dps_pkg::IX_OPMODE, 32'h3);
        acc(0, dps_pkg::IX_OPMODE, 32'h0);
    endtask
    task automatic t_lock_mode();
        acc(1, dps_pkg::IX_WLOCK, 32'h1);
        acc(1, dps_pkg::IX_BRAKE, 32'h0a);
        acc(0, dps_pkg::IX_BRAKE, 32'h3);
        acc(1, dps_pkg::IX_WLOCK, 32'h0);
        acc(1, dps_pkg::IX_OPMODE, 32'h2);
        acc(1, dps_pkg::IX_CTRL, 32'h0);
        chk(32'(o_ext_mode), 32'h1);
        acc(1, dps_pkg::IX_OPMODE, 32'h1);
        acc(1, dps_pkg::IX_CTRL, 32'h4);
        acc(0, dps_pkg::IX_OPMODE, 32'h1);
        chk(32'(o_ext_mode), 32'h0);
        acc(1, dps_pkg::IX_CTRL, 32'h0);
        acc(1, dps_pkg::IX_OPMODE, 32'h0);
    endtask
    task automatic t_run();
        int n;
        acc(1, dps_pkg::IX_RAMP1, 32'h1);
        acc(1, dps_pkg::IX_REVINH, 32'h1);
        acc(1, dps_pkg::IX_KFREQ, 32'h1770);
        acc(1, dps_pkg::IX_CTRL, 32'h3);
        repeat (3000) @(posedge i_clk);
        chk(32'(o_freq), 32'h0);
        acc(1, dps_pkg::IX_REVINH, 32'h0);
        for (n = 0; n < 12000 && o_freq === 16'h0; n++) @(posedge i_clk);
        chk(32'({o_dir_rev, n < 12000}), 32'h3);
        cmd <= 3'h4;
        repeat (12) @(posedge i_clk);
        chk({o_freq, 15'h0, o_out_en}, 32'h0);
        acc(1, dps_pkg::IX_RAMP2, 32'h1);
        repeat (4) @(posedge i_clk);
        chk(32'(o_out_en), 32'h1);
        cmd <= 3'h1;
        acc(1, dps_pkg::IX_CTRL, 32'h4);
        for (n = 0; n < 9000 && o_dir_rev !== 1'b0; n++) @(posedge i_clk);
        chk(32'({o_ext_mode, o_dir_rev}), 32'h2);
    endtask
    initial begin
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        t_reset();
        t_ranges();
        t_lock_mode();
        t_run();
        conclude();
    end
endmodule
bind dps_top dps_checker dps_checker_i (.i_clk, .i_reset, .i_hsel, .i_htrans, .i_hready,
    .o_hrdata, .o_hreadyout, .o_hresp, .o_freq, .o_dir_rev, .o_stall_en, .o_stall_pct,
    .o_brake_duty);
